// File: inc/motion_pkg.sv
// shared constants and types for the positioning command front end
package motion_pkg;
	localparam int NUM_CH = 2;
	localparam int ADDR_W = 8;
	// register byte offsets
	localparam logic [7:0] OFS_START = 8'h00;
	localparam logic [7:0] OFS_JOG = 8'h04;
	localparam logic [7:0] OFS_CTRL = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0c;
	localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h14;
	localparam logic [7:0] OFS_RAMP = 8'h18;
	// command field positions and widths
	localparam int F_COND = 0;
	localparam int F_CH = 1;
	localparam int CH_W = 2;
	localparam int F_DIR = 3;
	localparam int F_SPD = 4;
	localparam int F_STEP = 8;
	localparam int STEP_W = 5;
	localparam int F_CODE = 8;
	localparam int CODE_W = 2;
	// status layout, one half-word per channel
	localparam int ST_LANE = 16;
	// operand ranges and codes
	localparam logic [STEP_W-1:0] STEP_AUTO = 5'h00;
	localparam logic [STEP_W-1:0] STEP_FIRST = 5'h01;
	localparam logic [STEP_W-1:0] STEP_MAX = 5'h14;
	localparam logic [CODE_W-1:0] CODE_DECEL = 2'h0;
	localparam logic [CODE_W-1:0] CODE_EMERG = 2'h1;
	localparam logic [CODE_W-1:0] CODE_ERRRST = 2'h2;
	// pulse rates, in accumulator increments per clock
	localparam int RATE_W = 8;
	localparam logic [RATE_W-1:0] POS_RATE = 8'h40;
	localparam logic [RATE_W-1:0] JOG_HI = 8'h80;
	localparam logic [RATE_W-1:0] JOG_LO = 8'h10;
	// timing
	localparam int CLK_NS = 10;
	localparam int STEP_TIME_NS = 10000;
	localparam int STEP_CYCLES = STEP_TIME_NS / CLK_NS;
	localparam int CNT_W = 16;
	localparam logic [CNT_W-1:0] RAMP_RST = 16'h0004;
	// interrupt status bits
	localparam int IRQ_W = 5;
	localparam int IRQ_FAULT = 0;
	localparam int IRQ_DONE = 1;
	localparam int IRQ_ALARM = 3;
	typedef enum logic [1:0] {st_idle, st_pos, st_jog, st_decel} chan_state_t;
endpackage

// File: rtl/level_sync.sv
// two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ns
module level_sync #(
	parameter int W = 2
) (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// levels
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_ff;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_ff <= '0;
			q <= '0;
		end else if (ce) begin
			meta_ff <= d;
			q <= meta_ff;
		end
	end
endmodule

// File: rtl/motion_channel.sv
// one positioning channel: step run, jog, stops, alarm and pulse output
`timescale 1ns/1ns
module motion_channel (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// commands, strobes are one cycle
	input wire logic start_go,
	input wire logic [motion_pkg::STEP_W-1:0] start_step,
	input wire logic jog_on,
	input wire logic jog_fast,
	input wire logic jog_back,
	input wire logic stop_decel,
	input wire logic stop_emerg,
	input wire logic err_reset,
	input wire logic alarm,
	input wire logic [motion_pkg::CNT_W-1:0] ramp_div,
	// state and drive
	output motion_pkg::chan_state_t state_ff,
	output logic [motion_pkg::RATE_W-1:0] rate_ff,
	output logic [motion_pkg::STEP_W-1:0] step_ff,
	output logic dir_ff,
	output logic err_ff,
	output logic inhibit_ff,
	output logic done_ff,
	output logic pulse
);
	import motion_pkg::*;
	chan_state_t nxt_state;
	logic [RATE_W-1:0] nxt_rate;
	logic [STEP_W-1:0] nxt_step;
	logic auto_ff, nxt_auto, nxt_dir, nxt_done;
	logic [CNT_W-1:0] dwell_ff, ramp_ff;
	logic [RATE_W:0] acc_ff;
	wire tick = (ramp_ff == ramp_div);
	wire step_end = (dwell_ff == CNT_W'(STEP_CYCLES - 1));
	wire can_start = (state_ff == st_idle) && !inhibit_ff && !alarm;
	wire active = (state_ff != st_idle);
	assign pulse = acc_ff[RATE_W];

	always_comb begin
		nxt_state = state_ff;
		nxt_rate = rate_ff;
		nxt_step = step_ff;
		nxt_auto = auto_ff;
		nxt_dir = dir_ff;
		nxt_done = 1'b0;
		if (stop_emerg || alarm) begin
			nxt_state = st_idle;
			nxt_rate = '0;
			nxt_done = active;
		end else if (stop_decel && active) begin
			nxt_state = st_decel;
		end else begin
			unique case (state_ff)
				st_idle: begin
					if (can_start && start_go) begin
						nxt_state = st_pos;
						nxt_auto = (start_step == STEP_AUTO);
						nxt_step = nxt_auto ? STEP_FIRST : start_step;
						nxt_rate = POS_RATE;
						nxt_dir = 1'b0;
					end else if (can_start && jog_on) begin
						nxt_state = st_jog;
						nxt_dir = jog_back;
						nxt_rate = jog_fast ? RATE_W'(1) : JOG_LO;
					end
				end
				st_pos: begin
					if (step_end && auto_ff && step_ff < STEP_MAX) begin
						nxt_step = step_ff + STEP_W'(1);
					end else if (step_end) begin
						nxt_state = st_idle;
						nxt_rate = '0;
						nxt_done = 1'b1;
					end
				end
				st_jog: begin
					// direction is held from jog start on
					if (!jog_on && jog_fast) begin
						nxt_state = st_decel;
					end else if (!jog_on) begin
						nxt_state = st_idle;
						nxt_rate = '0;
						nxt_done = 1'b1;
					end else if (!jog_fast) begin
						nxt_rate = JOG_LO;
					end else if (tick && rate_ff < JOG_HI) begin
						nxt_rate = rate_ff + RATE_W'(1);
					end
				end
				st_decel: begin
					if (tick && rate_ff <= RATE_W'(1)) begin
						nxt_state = st_idle;
						nxt_rate = '0;
						nxt_done = 1'b1;
					end else if (tick) begin
						nxt_rate = rate_ff - RATE_W'(1);
					end
				end
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= st_idle;
			rate_ff <= '0;
			step_ff <= '0;
			auto_ff <= 1'b0;
			dir_ff <= 1'b0;
			done_ff <= 1'b0;
			dwell_ff <= '0;
			ramp_ff <= '0;
			acc_ff <= '0;
			err_ff <= 1'b0;
			inhibit_ff <= 1'b0;
		end else if (ce) begin
			state_ff <= nxt_state;
			rate_ff <= nxt_rate;
			step_ff <= nxt_step;
			auto_ff <= nxt_auto;
			dir_ff <= nxt_dir;
			done_ff <= nxt_done;
			dwell_ff <= (state_ff != st_pos || step_end) ? '0 :
				dwell_ff + CNT_W'(1);
			ramp_ff <= tick ? '0 : ramp_ff + CNT_W'(1);
			acc_ff <= {1'b0, acc_ff[RATE_W-1:0]} + {1'b0, rate_ff};
			// a new alarm wins over a reset in the same cycle
			err_ff <= alarm | (err_ff & ~err_reset);
			inhibit_ff <= alarm | (inhibit_ff & ~err_reset);
		end
	end
endmodule

// File: rtl/positioning_command_front_end.sv
// apb command front end for a two-channel pulse positioning engine
`timescale 1ns/1ns
module positioning_command_front_end (
	// clock, reset and freeze
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [motion_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// drive side, one bit per channel
	input wire logic [motion_pkg::NUM_CH-1:0] drive_alarm,
	output logic [motion_pkg::NUM_CH-1:0] pulse_out,
	output logic [motion_pkg::NUM_CH-1:0] dir_out,
	output logic [motion_pkg::NUM_CH-1:0] inhibit_out,
	// interrupt
	output logic irq
);
	import motion_pkg::*;

	// software-held command words and configuration
	logic [31:0] start_reg_ff, jog_reg_ff, ctrl_reg_ff;
	logic [CNT_W-1:0] ramp_ff;
	logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff, nxt_irq_stat;
	logic start_prev_ff, jog_prev_ff, ctrl_prev_ff;
	logic jog_run_ff;
	logic [CH_W-1:0] jog_ch_ff;
	logic [31:0] nxt_prdata;

	// apb decode
	wire access = psel && penable;
	wire done_xfer = access && pready;
	wire wr = done_xfer && pwrite;
	wire hit_start = (paddr == OFS_START);
	wire hit_jog = (paddr == OFS_JOG);
	wire hit_ctrl = (paddr == OFS_CTRL);
	wire hit_status = (paddr == OFS_STATUS);
	wire hit_istat = (paddr == OFS_IRQ_STAT);
	wire hit_imask = (paddr == OFS_IRQ_MASK);
	wire hit_ramp = (paddr == OFS_RAMP);
	wire mapped = hit_start | hit_jog | hit_ctrl | hit_status | hit_istat |
		hit_imask | hit_ramp;

	// command fields
	wire start_cond = start_reg_ff[F_COND];
	wire [CH_W-1:0] start_ch = start_reg_ff[F_CH +: CH_W];
	wire [STEP_W-1:0] start_step = start_reg_ff[F_STEP +: STEP_W];
	wire jog_cond = jog_reg_ff[F_COND];
	wire [CH_W-1:0] jog_ch = jog_reg_ff[F_CH +: CH_W];
	wire jog_back = jog_reg_ff[F_DIR];
	wire jog_fast = jog_reg_ff[F_SPD];
	wire ctrl_cond = ctrl_reg_ff[F_COND];
	wire [CH_W-1:0] ctrl_ch = ctrl_reg_ff[F_CH +: CH_W];
	wire [CODE_W-1:0] ctrl_code = ctrl_reg_ff[F_CODE +: CODE_W];

	// edges of the input conditions
	wire start_rise = start_cond && !start_prev_ff;
	wire jog_rise = jog_cond && !jog_prev_ff;
	wire ctrl_rise = ctrl_cond && !ctrl_prev_ff;

	// operand range checks
	wire start_ok = (start_ch < CH_W'(NUM_CH)) &&
		(start_step <= STEP_MAX);
	wire jog_ok = (jog_ch < CH_W'(NUM_CH));
	wire ctrl_ok = (ctrl_ch < CH_W'(NUM_CH)) &&
		(ctrl_code <= CODE_ERRRST);
	wire fault = ce && ((start_rise && !start_ok) ||
		(jog_rise && !jog_ok) || (ctrl_rise && !ctrl_ok));

	// per-channel wiring
	logic [NUM_CH-1:0] start_go, jog_on, stop_decel, stop_emerg, err_reset;
	logic [NUM_CH-1:0] alarm_sync, ch_err, ch_inh, ch_done, ch_pulse, ch_dir;
	logic [RATE_W-1:0] ch_rate [NUM_CH];
	logic [STEP_W-1:0] ch_step [NUM_CH];
	chan_state_t ch_state [NUM_CH];
	logic [31:0] status_word;

	// alarm pins come from the drive, outside our clock
	level_sync #(
		.W(NUM_CH)
	) u_alarm_sync (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.d(drive_alarm),
		.q(alarm_sync)
	);

	genvar gi;
	generate
		for (gi = 0; gi < NUM_CH; gi++) begin : g_ch
			wire sel_start = (start_ch == CH_W'(gi));
			wire sel_ctrl = (ctrl_ch == CH_W'(gi));
			wire ctrl_go = ce && ctrl_rise && ctrl_ok && sel_ctrl;
			assign start_go[gi] = ce && start_rise && start_ok &&
				sel_start;
			// jog stays on only while its condition is held
			assign jog_on[gi] = jog_run_ff && jog_cond &&
				(jog_ch_ff == CH_W'(gi));
			assign stop_decel[gi] = ctrl_go &&
				(ctrl_code == CODE_DECEL);
			assign stop_emerg[gi] = ctrl_go &&
				(ctrl_code == CODE_EMERG);
			assign err_reset[gi] = ctrl_go &&
				(ctrl_code == CODE_ERRRST);

			motion_channel u_ch (
				.pclk(pclk),
				.presetn(presetn),
				.ce(ce),
				.start_go(start_go[gi]),
				.start_step(start_step),
				.jog_on(jog_on[gi]),
				.jog_fast(jog_fast),
				.jog_back(jog_back),
				.stop_decel(stop_decel[gi]),
				.stop_emerg(stop_emerg[gi]),
				.err_reset(err_reset[gi]),
				.alarm(alarm_sync[gi]),
				.ramp_div(ramp_ff),
				.state_ff(ch_state[gi]),
				.rate_ff(ch_rate[gi]),
				.step_ff(ch_step[gi]),
				.dir_ff(ch_dir[gi]),
				.err_ff(ch_err[gi]),
				.inhibit_ff(ch_inh[gi]),
				.done_ff(ch_done[gi]),
				.pulse(ch_pulse[gi])
			);

			assign status_word[gi*ST_LANE +: ST_LANE] = {6'h00,
				ch_dir[gi], ch_inh[gi], ch_err[gi], ch_state[gi],
				ch_step[gi]};
			assign pulse_out[gi] = ch_pulse[gi];
			assign dir_out[gi] = ch_dir[gi];
			assign inhibit_out[gi] = ch_inh[gi];
		end
	endgenerate

	// events: fault, channel finished, alarm raised
	wire [IRQ_W-1:0] irq_events = {alarm_sync & ~ch_err, ch_done, fault};
	wire [IRQ_W-1:0] irq_clear = (wr && hit_istat) ?
		pwdata[IRQ_W-1:0] : '0;
	// set beats clear in the same cycle
	assign nxt_irq_stat = (irq_stat_ff & ~irq_clear) | irq_events;

	// read mux, registered while the access phase waits one cycle
	always_comb begin
		nxt_prdata = 32'h0000_0000;
		if (hit_start) begin
			nxt_prdata = start_reg_ff;
		end else if (hit_jog) begin
			nxt_prdata = jog_reg_ff;
		end else if (hit_ctrl) begin
			nxt_prdata = ctrl_reg_ff;
		end else if (hit_status) begin
			nxt_prdata = status_word;
		end else if (hit_istat) begin
			nxt_prdata = {{(32-IRQ_W){1'b0}}, irq_stat_ff};
		end else if (hit_imask) begin
			nxt_prdata = {{(32-IRQ_W){1'b0}}, irq_mask_ff};
		end else if (hit_ramp) begin
			nxt_prdata = {{(32-CNT_W){1'b0}}, ramp_ff};
		end
	end

	// bus handshake: one wait state so prdata comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h0000_0000;
		end else if (ce) begin
			pready <= access && !pready;
			pslverr <= access && !pready && !mapped;
			if (access && !pready && !pwrite) begin
				prdata <= nxt_prdata;
			end
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_reg_ff <= 32'h0000_0000;
			jog_reg_ff <= 32'h0000_0000;
			ctrl_reg_ff <= 32'h0000_0000;
			ramp_ff <= RAMP_RST;
			irq_mask_ff <= '0;
		end else if (ce && wr) begin
			if (hit_start) start_reg_ff <= pwdata;
			if (hit_jog) jog_reg_ff <= pwdata;
			if (hit_ctrl) ctrl_reg_ff <= pwdata;
			if (hit_ramp) ramp_ff <= pwdata[CNT_W-1:0];
			if (hit_imask) irq_mask_ff <= pwdata[IRQ_W-1:0];
		end
	end

	// condition history, jog ownership, interrupt
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			start_prev_ff <= 1'b0;
			jog_prev_ff <= 1'b0;
			ctrl_prev_ff <= 1'b0;
			jog_run_ff <= 1'b0;
			jog_ch_ff <= '0;
			irq_stat_ff <= '0;
			irq <= 1'b0;
		end else if (ce) begin
			start_prev_ff <= start_cond;
			jog_prev_ff <= jog_cond;
			ctrl_prev_ff <= ctrl_cond;
			// channel is latched at the edge so a later rewrite cannot move it
			if (jog_rise && jog_ok) begin
				jog_run_ff <= 1'b1;
				jog_ch_ff <= jog_ch;
			end else if (!jog_cond) begin
				jog_run_ff <= 1'b0;
			end
			irq_stat_ff <= nxt_irq_stat;
			irq <= |(nxt_irq_stat & irq_mask_ff);
		end
	end

	// checks
	a_fault_on_bad: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && start_rise && !start_ok) |=> irq_stat_ff[IRQ_FAULT])
		else $error("bad start operand did not raise the fault flag");

	a_no_restart: assert property (@(posedge pclk)
		disable iff (!presetn)
		(start_cond && start_prev_ff) |-> (start_go == '0))
		else $error("held start condition started again");

	a_bad_dropped: assert property (@(posedge pclk)
		disable iff (!presetn)
		((start_rise && !start_ok) || (ctrl_rise && !ctrl_ok)) |->
		(start_go == '0 && stop_decel == '0 && stop_emerg == '0 &&
		err_reset == '0))
		else $error("rejected command reached a channel");

	a_ctrl_once: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && (stop_decel | stop_emerg | err_reset) != '0) |=>
		((stop_decel | stop_emerg | err_reset) == '0))
		else $error("control command acted twice");

	a_range_two: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && ctrl_rise && ctrl_ch >= CH_W'(NUM_CH)) |=>
		irq_stat_ff[IRQ_FAULT])
		else $error("channel number out of range was accepted");

	a_start_step: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && start_go[0] && ch_state[0] == st_idle && !ch_inh[0] &&
		!alarm_sync[0] && stop_emerg[0] == 1'b0 && stop_decel[0] == 1'b0
		&& start_step != STEP_AUTO) |=>
		(ch_state[0] == st_pos && ch_step[0] == $past(start_step)))
		else $error("start did not begin at the given step");

	a_step_bound: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ch_state[0] == st_pos) |-> (ch_step[0] >= STEP_FIRST &&
		ch_step[0] <= STEP_MAX))
		else $error("positioning step outside 1 to 20");

	a_emerg_halt: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && stop_emerg[1]) |=>
		(ch_rate[1] == '0 && ch_state[1] == st_idle))
		else $error("emergency stop did not halt at once");

	a_decel_ramp: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && stop_decel[0] && ch_state[0] != st_idle &&
		!stop_emerg[0] && !alarm_sync[0]) |=>
		(ch_state[0] == st_decel && ch_rate[0] == $past(ch_rate[0])))
		else $error("deceleration stop skipped its ramp");

	a_dir_held: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ch_state[1] == st_jog && $past(ch_state[1]) == st_jog) |->
		$stable(ch_dir[1]))
		else $error("jog direction changed while jogging");

	a_low_flat: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && ch_state[0] == st_jog && jog_on[0] && !jog_fast &&
		!stop_emerg[0] && !stop_decel[0] && !alarm_sync[0]) |=>
		(ch_rate[0] == JOG_LO))
		else $error("slow jog not at its constant rate");

	a_err_clear: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && err_reset[1] && !alarm_sync[1]) |=>
		(!ch_err[1] && !inhibit_out[1]))
		else $error("error reset left error or inhibit set");

	a_jog_end: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && ch_state[1] == st_jog && !jog_on[1] && !jog_fast &&
		!stop_decel[1]) |=> (ch_state[1] == st_idle && ch_rate[1] == '0))
		else $error("slow jog did not stop when released");

	a_jog_start: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && jog_on[0] && !start_go[0] && ch_state[0] == st_idle &&
		!ch_inh[0] && !alarm_sync[0] && !stop_emerg[0]) |=>
		(ch_state[0] == st_jog))
		else $error("held jog condition did not start the jog");

	a_jog_dir: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ch_state[0] == st_jog && $past(ch_state[0]) == st_idle) |->
		(ch_dir[0] == $past(jog_back)))
		else $error("jog started in the wrong direction");

	a_fast_ramp: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && ch_state[0] == st_jog && jog_on[0] && jog_fast &&
		!stop_emerg[0] && !stop_decel[0] && !alarm_sync[0]) |=>
		(ch_rate[0] == $past(ch_rate[0]) ||
		ch_rate[0] == $past(ch_rate[0]) + RATE_W'(1)))
		else $error("fast jog rate jumped instead of ramping");

	a_fast_release: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && ch_state[0] == st_jog && !jog_on[0] && jog_fast &&
		!stop_emerg[0] && !alarm_sync[0]) |=> (ch_state[0] == st_decel))
		else $error("released fast jog skipped its slowdown");

	a_jog_fault: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ce && jog_rise && !jog_ok) |=>
		(irq_stat_ff[IRQ_FAULT] && !jog_run_ff))
		else $error("bad jog operand was not rejected");
endmodule

// File: sim/apb_cmd_master.sv
// apb master model standing in for the controller sequence program
`timescale 1ns/1ns
module apb_cmd_master (
	// clock
	input wire logic pclk,
	// apb request
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [motion_pkg::ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	// apb answer
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	import motion_pkg::*;
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
	end
	task automatic xfer(input logic wr, input logic [7:0] a,
		input logic [31:0] dw, output logic [31:0] dr, output logic er);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= dw;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		dr = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// released lines must not keep showing the last value
		paddr <= ~a;
		pwdata <= ~dw;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] dw);
		logic [31:0] dr;
		logic er;
		xfer(1'b1, a, dw, dr, er);
	endtask
	task automatic start_cmd(input logic [1:0] ch, input logic [4:0] step,
		input logic cond);
		wr(OFS_START, {19'h0, step, 5'h0, ch, cond});
	endtask
	task automatic jog_cmd(input logic [1:0] ch, input logic back,
		input logic fast, input logic cond);
		wr(OFS_JOG, {27'h0, fast, back, ch, cond});
	endtask
	task automatic ctrl_cmd(input logic [1:0] ch, input logic [1:0] code,
		input logic cond);
		wr(OFS_CTRL, {22'h0, code, 5'h0, ch, cond});
	endtask
endmodule

// File: sim/tb.sv
// self-checking bench for the positioning command front end
`timescale 1ns/1ns
module tb;
	import motion_pkg::*;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, irq;
	logic [ADDR_W-1:0] paddr;
	logic [31:0] pwdata, prdata, d;
	logic [NUM_CH-1:0] drive_alarm, pulse_out, dir_out, inhibit_out;
	logic err;
	int errors, cmp_count, npulse;
	positioning_command_front_end uut (.pclk(pclk), .presetn(presetn),
		.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .drive_alarm(drive_alarm), .pulse_out(pulse_out),
		.dir_out(dir_out), .inhibit_out(inhibit_out), .irq(irq));
	apb_cmd_master bus (.pclk(pclk), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	task automatic complete_run;
		$display("errors %0d comparisons %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string name, input logic [31:0] exp,
		input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			errors++;
			$display("wrong value %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic rd(input logic [7:0] a);
		bus.xfer(1'b0, a, 32'h0, d, err);
	endtask
	task automatic chk_state(input int ch, input chan_state_t exp);
		rd(OFS_STATUS);
		chk("state", 32'(exp), 32'(d[16*ch+5 +: 2]));
	endtask
	task automatic count_pulses(input int ch, input int n);
		npulse = 0;
		repeat (n) begin
			@(posedge pclk);
			if (pulse_out[ch] === 1'b1)
				npulse++;
		end
	endtask
	// generous bound, the sequence needs roughly 5500 cycles
	initial begin
		repeat (60000) @(posedge pclk);
		errors++;
		complete_run();
	end
	initial begin
		errors = 0;
		cmp_count = 0;
		ce = 1'b1;
		drive_alarm = 2'h0;
		presetn = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFS_STATUS);
		chk("status reset", 32'h0, d);
		rd(OFS_RAMP);
		chk("ramp reset", 32'(RAMP_RST), d);
		rd(OFS_IRQ_MASK);
		chk("mask reset", 32'h0, d);
		bus.xfer(1'b0, 8'h1c, 32'h0, d, err);
		chk("unmapped err", 32'h1, {31'h0, err});
		chk("unmapped data", 32'h0, d);
		for (int i = 0; i < 4; i++) begin
			case (i)
				0: bus.start_cmd(2'h2, 5'h01, 1'b1);
				1: bus.start_cmd(2'h0, 5'h15, 1'b1);
				2: bus.jog_cmd(2'h3, 1'b0, 1'b0, 1'b1);
				default: bus.ctrl_cmd(2'h0, 2'h3, 1'b1);
			endcase
			repeat (3) @(posedge pclk);
			rd(OFS_IRQ_STAT);
			chk("fault flag", 32'h1, d);
			rd(OFS_STATUS);
			chk("status kept", 32'h0, d);
			bus.wr(OFS_IRQ_MASK, 32'h1);
			repeat (2) @(posedge pclk);
			chk("irq on", 32'h1, 32'(irq));
			bus.wr(OFS_IRQ_STAT, 32'h1);
			repeat (2) @(posedge pclk);
			chk("irq off", 32'h0, 32'(irq));
			bus.wr(OFS_IRQ_MASK, 32'h0);
			bus.wr(OFS_START, 32'h0);
			bus.wr(OFS_JOG, 32'h0);
			bus.wr(OFS_CTRL, 32'h0);
		end
		bus.start_cmd(2'h0, 5'h05, 1'b1);
		rd(OFS_STATUS);
		chk("start", 32'h25, 32'(d[6:0]));
		repeat (1100) @(posedge pclk);
		chk_state(0, st_idle);
		bus.start_cmd(2'h0, 5'h05, 1'b1);
		repeat (3) @(posedge pclk);
		chk_state(0, st_idle);
		rd(OFS_IRQ_STAT);
		chk("done", 32'h1, 32'(d[1]));
		bus.start_cmd(2'h0, 5'h05, 1'b0);
		bus.wr(OFS_IRQ_STAT, 32'h1f);
		bus.start_cmd(2'h1, 5'h00, 1'b1);
		repeat (1500) @(posedge pclk);
		rd(OFS_STATUS);
		chk("auto step", 32'h2, 32'(d[20:16]));
		bus.ctrl_cmd(2'h1, CODE_EMERG, 1'b1);
		chk_state(1, st_idle);
		count_pulses(1, 64);
		chk("halted", 32'h0, 32'(npulse));
		bus.ctrl_cmd(2'h1, CODE_EMERG, 1'b0);
		bus.start_cmd(2'h1, 5'h00, 1'b0);
		bus.jog_cmd(2'h0, 1'b0, 1'b0, 1'b1);
		chk_state(0, st_jog);
		count_pulses(0, 256);
		chk("slow", 32'h1, 32'(npulse >= 15 && npulse <= 17));
		chk("fwd", 32'h0, 32'(dir_out[0]));
		bus.jog_cmd(2'h0, 1'b1, 1'b1, 1'b1);
		repeat (700) @(posedge pclk);
		chk("dir held", 32'h0, 32'(dir_out[0]));
		count_pulses(0, 256);
		chk("fast", 32'h1, 32'(npulse >= 127 && npulse <= 129));
		bus.jog_cmd(2'h0, 1'b1, 1'b1, 1'b0);
		chk_state(0, st_decel);
		repeat (800) @(posedge pclk);
		chk_state(0, st_idle);
		bus.jog_cmd(2'h1, 1'b1, 1'b0, 1'b1);
		repeat (3) @(posedge pclk);
		chk("back", 32'h1, 32'(dir_out[1]));
		bus.jog_cmd(2'h1, 1'b1, 1'b0, 1'b0);
		chk_state(1, st_idle);
		bus.start_cmd(2'h0, 5'h03, 1'b1);
		repeat (10) @(posedge pclk);
		bus.ctrl_cmd(2'h0, CODE_DECEL, 1'b1);
		chk_state(0, st_decel);
		repeat (400) @(posedge pclk);
		chk_state(0, st_idle);
		bus.start_cmd(2'h0, 5'h03, 1'b0);
		bus.start_cmd(2'h0, 5'h03, 1'b1);
		repeat (10) @(posedge pclk);
		chk_state(0, st_pos);
		bus.ctrl_cmd(2'h0, CODE_DECEL, 1'b0);
		bus.ctrl_cmd(2'h0, CODE_EMERG, 1'b1);
		chk_state(0, st_idle);
		// condition back to zero so the reset below sees a fresh edge
		bus.ctrl_cmd(2'h0, CODE_EMERG, 1'b0);
		// frozen clock enable must hide an alarm pulse entirely
		ce <= 1'b0;
		drive_alarm <= 2'h1;
		repeat (5) @(posedge pclk);
		drive_alarm <= 2'h0;
		repeat (3) @(posedge pclk);
		ce <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("frozen", 32'h0, 32'(inhibit_out));
		drive_alarm <= 2'h2;
		repeat (5) @(posedge pclk);
		drive_alarm <= 2'h0;
		repeat (3) @(posedge pclk);
		chk("inhibit", 32'h2, 32'(inhibit_out));
		rd(OFS_STATUS);
		chk("err set", 32'h3, 32'(d[24:23]));
		rd(OFS_IRQ_STAT);
		chk("alarm bit", 32'h1, 32'(d[4]));
		bus.ctrl_cmd(2'h1, CODE_ERRRST, 1'b1);
		repeat (3) @(posedge pclk);
		chk("inhibit off", 32'h0, 32'(inhibit_out));
		rd(OFS_STATUS);
		chk("err clear", 32'h0, 32'(d[24:23]));
		complete_run();
	end
endmodule
